// ### scsr_pkg.sv
`default_nettype none
package scsr_pkg;
    // clock and control tick
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
    // register indices, byte address is four times the index
    localparam logic [11:0] IDX_ACCEL = 12'h144;
    localparam logic [11:0] IDX_DECEL = 12'h146;
    localparam logic [11:0] IDX_BLEND = 12'h148;
    localparam logic [11:0] IDX_FULL_SCALE = 12'h150;
    localparam logic [11:0] IDX_PRESET1 = 12'h300;
    localparam logic [11:0] IDX_PRESET2 = 12'h302;
    localparam logic [11:0] IDX_PRESET3 = 12'h304;
    localparam logic [11:0] IDX_CTRL_MODE = 12'h306;
    localparam logic [11:0] IDX_TUNING = 12'h308;
    localparam logic [11:0] IDX_STATUS = 12'h30a;
    localparam logic [11:0] IDX_COMMAND = 12'h30c;
    // ramp and blend times in ms
    localparam logic [15:0] RAMP_TIME_RST = 16'h00c8;
    localparam logic [15:0] RAMP_TIME_MIN = 16'h0001;
    localparam logic [15:0] RAMP_TIME_MAX = 16'h4e20;
    localparam logic [15:0] BLEND_RST = 16'h0000;
    localparam logic [15:0] BLEND_MAX = 16'h2710;
    // analog full scale in r/min at 10 V
    localparam logic [15:0] FULL_SCALE_RST = 16'h0bb8;
    localparam logic [15:0] FULL_SCALE_MAX = 16'h2710;
    localparam logic [19:0] RPM_TO_CMD = 20'h0000a;
    localparam int unsigned ANALOG_SHIFT = 15;
    // preset speeds in 0.1 r/min
    localparam logic signed [17:0] PRESET_MAX = 18'sh0c350;
    localparam logic signed [17:0] PRESET_MIN = -18'sh0c350;
    localparam logic signed [17:0] PRESET_RST = 18'sh00000;
    // rated speed (0.1 r/min) in q8 fixed point
    localparam logic [31:0] RATED_Q8 = 32'h0075_3000;
    localparam int unsigned FRAC_BITS = 8;
    // tuning register fields
    localparam int unsigned TUNE_AUTO_BIT = 0;
    localparam int unsigned TUNE_LVL_LSB = 4;
    localparam logic [3:0] TUNE_LVL_MIN = 4'h1;
    localparam logic [3:0] TUNE_LVL_MAX = 4'ha;
    localparam logic [3:0] TUNE_LVL_RST = 4'h5;

    typedef enum logic [1:0] {
        MODE_SPEED,
        MODE_SPEED_ZERO,
        MODE_TORQUE,
        MODE_TORQUE_ZERO
    } scsr_mode_t;

    typedef enum logic [1:0] {
        SRC_ANALOG,
        SRC_ZERO,
        SRC_PRESET
    } scsr_src_t;

    localparam scsr_mode_t CTRL_MODE_RST = MODE_SPEED;
endpackage
`default_nettype wire

// ### scsr_scurve.sv
`timescale 1ns/100ps
`default_nettype none
module scsr_scurve
    import scsr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // control
    input wire logic tick_in,
    input wire logic bypass_in,
    input wire logic signed [17:0] target_in,
    // times in ms
    input wire logic [15:0] accel_ms_in,
    input wire logic [15:0] decel_ms_in,
    input wire logic [15:0] blend_ms_in,
    // shaped command
    output logic signed [17:0] cmd_out
);
    logic signed [31:0] vel_r, vel_nxt;
    logic signed [31:0] acc_r, acc_nxt;
    logic snap_r, snap_nxt;
    logic signed [31:0] tgt_q, err, a_goal;
    logic [31:0] err_abs, acc_abs, amax, jerk, t_ramp;
    logic [63:0] brake_dist, acc_sq;
    logic dir_neg, brake;

    always_comb
    begin
        tgt_q = 32'(target_in) <<< FRAC_BITS;
        err = tgt_q - vel_r;
        dir_neg = err[31];
        err_abs = dir_neg ? 32'(-err) : 32'(err);
        acc_abs = acc_r[31] ? 32'(-acc_r) : 32'(acc_r);
        // accel time while moving away from zero, decel time otherwise
        if ((tgt_q[31] ? -tgt_q : tgt_q) >= (vel_r[31] ? -vel_r : vel_r))
            t_ramp = {16'h0000, accel_ms_in};
        else
            t_ramp = {16'h0000, decel_ms_in};
        amax = RATED_Q8 / t_ramp;
        // blend spreads the accel change over its time, zero gives a plain ramp
        if (blend_ms_in == BLEND_RST)
            jerk = amax;
        else
            jerk = amax / {16'h0000, blend_ms_in};
        if (jerk == 32'h0)
            jerk = 32'h1;
        acc_sq = 64'(acc_abs) * 64'(acc_abs);
        brake_dist = (64'(jerk) * 64'(err_abs)) << 1;
        brake = (dir_neg ? acc_r < 0 : acc_r > 0) && (brake_dist <= acc_sq);
        a_goal = brake ? 32'sh0 : (dir_neg ? -$signed(amax) : $signed(amax));
        acc_nxt = acc_r;
        vel_nxt = vel_r;
        snap_nxt = snap_r;
        if (tick_in)
        begin
            snap_nxt = 1'b0;
            if (bypass_in)
            begin
                acc_nxt = 32'sh0;
                vel_nxt = tgt_q;
            end
            else
            begin
                if (acc_r < a_goal)
                    acc_nxt = (a_goal - acc_r > $signed(jerk)) ?
                        acc_r + $signed(jerk) : a_goal;
                else
                    acc_nxt = (acc_r - a_goal > $signed(jerk)) ?
                        acc_r - $signed(jerk) : a_goal;
                vel_nxt = vel_r + acc_nxt;
                if (err == 32'sh0 ||
                    (dir_neg ? vel_nxt <= tgt_q : vel_nxt >= tgt_q))
                begin
                    vel_nxt = tgt_q;
                    acc_nxt = 32'sh0;
                    snap_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            vel_r <= 32'sh0;
            acc_r <= 32'sh0;
            snap_r <= 1'b0;
        end
        else
        begin
            vel_r <= vel_nxt;
            acc_r <= acc_nxt;
            snap_r <= snap_nxt;
        end
    end

    assign cmd_out = vel_r[25:8];

    a_tick_update: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        !tick_in |=> $stable(vel_r))
        else $error("ramp output moved outside a control tick");

    a_bypass_follow: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        tick_in && bypass_in |=> cmd_out == $past(target_in) && acc_r == 0)
        else $error("bypassed ramp did not follow target");

    a_jerk_bound: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        tick_in && !bypass_in |=> snap_r ||
        ((acc_r - $past(acc_r) <= $signed($past(jerk))) &&
         ($past(acc_r) - acc_r <= $signed($past(jerk)))))
        else $error("acceleration stepped by more than one jerk step");

    c_ramp_settle: cover property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        tick_in && !bypass_in ##1 snap_r);
endmodule
`default_nettype wire

// ### scsr_top.sv
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module scsr_top
    import scsr_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [13:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // controller select contacts and analog input
    input wire logic speed_select_bit0_in,
    input wire logic speed_select_bit1_in,
    input wire logic signed [15:0] analog_code_in,
    // command outputs
    output logic signed [17:0] speed_command_out,
    output logic signed [17:0] speed_limit_out,
    output logic auto_tune_en_out,
    output logic [3:0] bandwidth_level_out
);
    // register group
    logic [15:0] accel_r, accel_nxt;
    logic [15:0] decel_r, decel_nxt;
    logic [15:0] blend_r, blend_nxt;
    logic [15:0] full_scale_r, full_scale_nxt;
    logic signed [17:0] preset_r [3], preset_nxt [3];
    scsr_mode_t mode_r, mode_nxt;
    logic tune_auto_r, tune_auto_nxt;
    logic [3:0] tune_lvl_r, tune_lvl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [11:0] idx;
    logic wr_en;
    logic [31:0] rd_val;
    logic mapped;
    // command group
    logic [1:0] sel;
    logic [1:0] sel_prev_r, sel_prev_nxt;
    logic signed [17:0] preset_lat_r, preset_lat_nxt;
    logic signed [17:0] analog_r, analog_nxt;
    logic signed [17:0] target_r, target_nxt;
    scsr_src_t src_r, src_nxt;
    logic signed [17:0] cmd_r, cmd_nxt;
    logic signed [17:0] limit_r, limit_nxt;
    logic auto_en_r, auto_en_nxt;
    logic [3:0] bw_r, bw_nxt;
    logic [19:0] scale_gain;
    logic signed [36:0] analog_prod;
    logic torque_mode;
    logic bypass;
    logic signed [17:0] ramp_cmd;
    // tick group
    logic [15:0] tick_cnt_r, tick_cnt_nxt;
    logic tick_r, tick_nxt;

    function automatic logic [15:0] clamp_u16(input logic [31:0] val,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
        logic [15:0] res;
        res = val[15:0];
        if (val > {16'h0000, hi})
            res = hi;
        else if (val < {16'h0000, lo})
            res = lo;
        return res;
    endfunction

    function automatic logic signed [17:0] clamp_preset(input logic [31:0] val);
        logic signed [17:0] res;
        res = val[17:0];
        if ($signed(val) > 32'(PRESET_MAX))
            res = PRESET_MAX;
        else if ($signed(val) < 32'(PRESET_MIN))
            res = PRESET_MIN;
        return res;
    endfunction

    // apb register file, zero wait states, answer in the first access cycle
    always_comb
    begin
        accel_nxt = accel_r;
        decel_nxt = decel_r;
        blend_nxt = blend_r;
        full_scale_nxt = full_scale_r;
        preset_nxt = preset_r;
        mode_nxt = mode_r;
        tune_auto_nxt = tune_auto_r;
        tune_lvl_nxt = tune_lvl_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        pready_nxt = psel_in && !penable_in;
        idx = paddr_in[13:2];
        wr_en = psel_in && penable_in && pready_r && pwrite_in && !pslverr_r;
        rd_val = 32'h0;
        mapped = (paddr_in[1:0] == 2'b00);
        if (idx == IDX_ACCEL)
        begin
            rd_val = {16'h0000, accel_r};
            if (wr_en)
                accel_nxt = clamp_u16(pwdata_in, RAMP_TIME_MIN, RAMP_TIME_MAX);
        end
        else if (idx == IDX_DECEL)
        begin
            rd_val = {16'h0000, decel_r};
            if (wr_en)
                decel_nxt = clamp_u16(pwdata_in, RAMP_TIME_MIN, RAMP_TIME_MAX);
        end
        else if (idx == IDX_BLEND)
        begin
            rd_val = {16'h0000, blend_r};
            if (wr_en)
                blend_nxt = clamp_u16(pwdata_in, BLEND_RST, BLEND_MAX);
        end
        else if (idx == IDX_FULL_SCALE)
        begin
            rd_val = {16'h0000, full_scale_r};
            if (wr_en)
                full_scale_nxt = clamp_u16(pwdata_in, 16'h0000, FULL_SCALE_MAX);
        end
        else if (idx == IDX_PRESET1 || idx == IDX_PRESET2 ||
                 idx == IDX_PRESET3)
        begin
            rd_val = 32'(preset_r[idx[2:1]]);
            if (wr_en)
                preset_nxt[idx[2:1]] = clamp_preset(pwdata_in);
        end
        else if (idx == IDX_CTRL_MODE)
        begin
            rd_val = {30'h0, mode_r};
            if (wr_en)
                mode_nxt = scsr_mode_t'(pwdata_in[1:0]);
        end
        else if (idx == IDX_TUNING)
        begin
            rd_val[TUNE_AUTO_BIT] = tune_auto_r;
            rd_val[TUNE_LVL_LSB +: 4] = tune_lvl_r;
            if (wr_en)
            begin
                tune_auto_nxt = pwdata_in[TUNE_AUTO_BIT];
                tune_lvl_nxt = 4'(clamp_u16(
                    {28'h0, pwdata_in[TUNE_LVL_LSB +: 4]},
                    {12'h0, TUNE_LVL_MIN}, {12'h0, TUNE_LVL_MAX}));
            end
        end
        else if (idx == IDX_STATUS)
            rd_val = {28'h0, sel_prev_r, src_r};
        else if (idx == IDX_COMMAND)
            rd_val = 32'(ramp_cmd);
        else
            mapped = 1'b0;
        if (psel_in && !penable_in)
        begin
            prdata_nxt = mapped ? rd_val : 32'h0;
            pslverr_nxt = !mapped;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            accel_r <= RAMP_TIME_RST;
            decel_r <= RAMP_TIME_RST;
            blend_r <= BLEND_RST;
            full_scale_r <= FULL_SCALE_RST;
            preset_r <= '{PRESET_RST, PRESET_RST, PRESET_RST};
            mode_r <= CTRL_MODE_RST;
            tune_auto_r <= 1'b0;
            tune_lvl_r <= TUNE_LVL_RST;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            accel_r <= accel_nxt;
            decel_r <= decel_nxt;
            blend_r <= blend_nxt;
            full_scale_r <= full_scale_nxt;
            preset_r <= preset_nxt;
            mode_r <= mode_nxt;
            tune_auto_r <= tune_auto_nxt;
            tune_lvl_r <= tune_lvl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // 1 ms control tick
    always_comb
    begin
        tick_nxt = 1'b0;
        tick_cnt_nxt = tick_cnt_r + 16'h0001;
        if (tick_cnt_r == 16'(TICK_LEN - 1))
        begin
            tick_cnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // command source selection
    always_comb
    begin
        sel = {speed_select_bit1_in, speed_select_bit0_in};
        torque_mode = (mode_r == MODE_TORQUE) || (mode_r == MODE_TORQUE_ZERO);
        scale_gain = 20'(full_scale_r) * RPM_TO_CMD;
        analog_prod = $signed(analog_code_in) * $signed({1'b0, scale_gain});
        analog_nxt = analog_prod[ANALOG_SHIFT +: 18];
        sel_prev_nxt = sel;
        preset_lat_nxt = preset_lat_r;
        if (sel != sel_prev_r && sel != 2'b00)
            preset_lat_nxt = preset_r[sel - 2'b01];
        target_nxt = preset_lat_r;
        src_nxt = SRC_PRESET;
        if (sel_prev_r == 2'b00)
        begin
            if (mode_r == MODE_SPEED_ZERO || mode_r == MODE_TORQUE_ZERO)
            begin
                target_nxt = 18'sh00000;
                src_nxt = SRC_ZERO;
            end
            else
            begin
                target_nxt = analog_r;
                src_nxt = SRC_ANALOG;
            end
        end
        bypass = (src_r == SRC_ANALOG) && (blend_r == BLEND_RST);
        cmd_nxt = torque_mode ? 18'sh00000 : ramp_cmd;
        limit_nxt = torque_mode ? ramp_cmd : 18'sh00000;
        auto_en_nxt = tune_auto_r;
        bw_nxt = tune_auto_r ? tune_lvl_r : 4'h0;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sel_prev_r <= 2'b00;
            preset_lat_r <= PRESET_RST;
            analog_r <= 18'sh00000;
            target_r <= 18'sh00000;
            src_r <= SRC_ANALOG;
            cmd_r <= 18'sh00000;
            limit_r <= 18'sh00000;
            auto_en_r <= 1'b0;
            bw_r <= 4'h0;
        end
        else
        begin
            sel_prev_r <= sel_prev_nxt;
            preset_lat_r <= preset_lat_nxt;
            analog_r <= analog_nxt;
            target_r <= target_nxt;
            src_r <= src_nxt;
            cmd_r <= cmd_nxt;
            limit_r <= limit_nxt;
            auto_en_r <= auto_en_nxt;
            bw_r <= bw_nxt;
        end
    end

    scsr_scurve u_scurve (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .tick_in(tick_r),
        .bypass_in(bypass),
        .target_in(target_r),
        .accel_ms_in(accel_r),
        .decel_ms_in(decel_r),
        .blend_ms_in(blend_r),
        .cmd_out(ramp_cmd)
    );

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign speed_command_out = cmd_r;
    assign speed_limit_out = limit_r;
    assign auto_tune_en_out = auto_en_r;
    assign bandwidth_level_out = bw_r;

    a_zero_mode_cmd: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        sel_prev_r == 2'b00 && mode_r == MODE_SPEED_ZERO
        |=> target_r == 0 && src_r == SRC_ZERO)
        else $error("zero mode did not force a zero command");

    a_analog_source: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        sel_prev_r == 2'b00 && mode_r == MODE_SPEED
        |=> target_r == $past(analog_r))
        else $error("analog mode did not take the analog command");

    a_analog_sign: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        analog_code_in == 16'sh4000 && full_scale_r == FULL_SCALE_RST
        |=> analog_r == 18'sh03a98)
        else $error("half scale analog input scaled wrongly");

    a_preset_pick: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        sel != sel_prev_r && sel == 2'b10
        |=> ##1 target_r == $past(preset_r[1], 2))
        else $error("select 10 did not pick the second preset");

    a_preset_hold: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        sel == sel_prev_r && sel_prev_r != 2'b00 |=> $stable(preset_lat_r))
        else $error("preset changed without a select input change");

    a_preset_range: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        preset_r[0] <= PRESET_MAX && preset_r[0] >= PRESET_MIN &&
        preset_r[1] <= PRESET_MAX && preset_r[1] >= PRESET_MIN &&
        preset_r[2] <= PRESET_MAX && preset_r[2] >= PRESET_MIN)
        else $error("preset outside its range");

    a_ramp_range: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        accel_r >= RAMP_TIME_MIN && accel_r <= RAMP_TIME_MAX &&
        decel_r >= RAMP_TIME_MIN && decel_r <= RAMP_TIME_MAX)
        else $error("ramp time outside its range");

    a_blend_range: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        blend_r <= BLEND_MAX)
        else $error("blend time outside its range");

    a_torque_limit: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        torque_mode |=> speed_command_out == 0 &&
        speed_limit_out == $past(ramp_cmd))
        else $error("torque mode did not route command to limit");

    a_manual_aux: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        !tune_auto_r |=> !auto_tune_en_out && bandwidth_level_out == 0)
        else $error("manual tuning left auto functions on");

    a_apb_answer: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        psel_in && !penable_in |=> pready_out)
        else $error("apb access phase not answered at once");

    c_preset_switch: cover property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        sel_prev_r == 2'b01 ##1 sel_prev_r == 2'b11);

    c_analog_bypass: cover property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        bypass && tick_r);

    c_torque_limit: cover property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        torque_mode && speed_limit_out != 0);

    c_apb_error: cover property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        pready_out && pslverr_out);
endmodule
`default_nettype wire

// ### scsr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module scsr_ctrl_model
(
    // clock
    input wire logic ref_clk_in,
    // wanted contact pair, bit1 then bit0
    input wire logic [1:0] pair_in,
    // contacts toward the drive
    output var logic speed_select_bit0_out,
    output var logic speed_select_bit1_out
);
    initial
    begin
        speed_select_bit0_out = 1'b0;
        speed_select_bit1_out = 1'b0;
    end
    // 1 closes a contact, 0 leaves it open
    always @(posedge ref_clk_in)
    begin
        speed_select_bit0_out <= pair_in[0];
        speed_select_bit1_out <= pair_in[1];
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import scsr_pkg::*;
    localparam int TL = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sb0, sb1, auto_en, err;
    logic [1:0] pair = 2'h0;
    logic signed [15:0] acode = 16'sh0000;
    logic signed [17:0] scmd, slim;
    logic [3:0] bw;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 32'had25;
    int pre[3] = '{0, 0, 0};
    int lat = 0;
    int mode = 0;
    int fs = 3000;
    int v;
    always #10 clk = ~clk;
    scsr_ctrl_model i_ctrl (.ref_clk_in(clk), .pair_in(pair),
        .speed_select_bit0_out(sb0), .speed_select_bit1_out(sb1));
    scsr_top #(.TICK_LEN(TL)) i_dut (.ref_clk_in(clk), .resetn_in(rst_n),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .speed_select_bit0_in(sb0), .speed_select_bit1_in(sb1),
        .analog_code_in(acode), .speed_command_out(scmd),
        .speed_limit_out(slim), .auto_tune_en_out(auto_en),
        .bandwidth_level_out(bw));
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input int exp);
        total_checks++;
        if (got !== exp[31:0])
        begin
            fail_count++;
            $display("mismatch at %0t: read %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_cmd(input logic signed [17:0] got, input int exp);
        total_checks++;
        if (got !== exp[17:0])
        begin
            fail_count++;
            $display("mismatch at %0t: cmd %0d want %0d", $time, got, exp);
        end
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] idx, input int wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1)
        begin
            check_reg(32'h0000_0000, 1);
            final_report();
        end
    endtask
    function automatic int model_cmd();
        if (pair != 2'h0)
            return lat;
        if (mode == 1 || mode == 3)
            return 0;
        return int'((longint'(acode) * fs * 10) >>> 15);
    endfunction
    task automatic setsel(input int p);
        pair <= p[1:0];
        if (p != 0)
            lat = pre[p - 1];
        @(posedge clk);
    endtask
    task automatic wait_out(input logic lim, input int exp);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while ((lim ? slim : scmd) !== exp[17:0] && n < 40 * TL);
        check_cmd(lim ? slim : scmd, exp);
        if ((lim ? slim : scmd) !== exp[17:0])
            final_report();
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, IDX_ACCEL, 0);
        check_reg(rd, 200);
        apb(0, IDX_DECEL, 0);
        check_reg(rd, 200);
        apb(0, 12'h001, 0);
        check_reg({31'h0, err}, 1);
        apb(1, IDX_ACCEL, 0);
        apb(0, IDX_ACCEL, 0);
        check_reg(rd, 1);
        apb(1, IDX_ACCEL, 30000);
        apb(0, IDX_ACCEL, 0);
        check_reg(rd, 20000);
        v = 1 + ($unsigned($random(seed)) % 20000);
        apb(1, IDX_DECEL, v);
        apb(0, IDX_DECEL, 0);
        check_reg(rd, v);
        apb(1, IDX_BLEND, 20000);
        apb(0, IDX_BLEND, 0);
        check_reg(rd, 10000);
        apb(1, IDX_BLEND, 0);
        apb(1, IDX_ACCEL, 1);
        apb(1, IDX_DECEL, 1);
        pre = '{1000, -2000, 50000};
        apb(1, IDX_PRESET1, 1000);
        apb(1, IDX_PRESET2, -2000);
        apb(1, IDX_PRESET3, 60000);
        apb(0, IDX_PRESET3, 0);
        check_reg(rd, 50000);
        apb(0, IDX_PRESET2, 0);
        check_reg(rd, -2000);
        acode <= 16'sh4000;
        @(posedge clk);
        wait_out(0, model_cmd());
        for (int i = 1; i < 4; i++)
        begin
            setsel(i);
            wait_out(0, model_cmd());
        end
        setsel(1);
        wait_out(0, model_cmd());
        apb(1, IDX_PRESET1, 3000);
        pre[0] = 3000;
        repeat (5 * TL) @(posedge clk);
        check_cmd(scmd, lat);
        setsel(2);
        wait_out(0, model_cmd());
        setsel(1);
        wait_out(0, model_cmd());
        // non-zero blend: one tick must not carry the full step
        apb(1, IDX_BLEND, 4);
        setsel(3);
        repeat (TL) @(posedge clk);
        check_reg({31'h0, scmd != lat}, 1);
        wait_out(0, model_cmd());
        apb(0, IDX_STATUS, 0);
        check_reg(rd, 32'h0000_000e);
        apb(0, IDX_COMMAND, 0);
        check_reg(rd, lat);
        apb(1, IDX_BLEND, 0);
        apb(1, IDX_FULL_SCALE, 5000);
        fs = 5000;
        setsel(0);
        for (int i = 0; i < 3; i++)
        begin
            acode <= $random(seed);
            @(posedge clk);
            wait_out(0, model_cmd());
        end
        for (int m = 1; m < 4; m++)
        begin
            apb(1, IDX_CTRL_MODE, m);
            mode = m;
            wait_out(m >= 2, model_cmd());
            if (m >= 2)
                check_cmd(scmd, 0);
        end
        apb(1, IDX_TUNING, 32'h0000_00f1);
        repeat (2) @(posedge clk);
        check_reg({28'h0, bw}, 10);
        check_reg({31'h0, auto_en}, 1);
        apb(1, IDX_TUNING, 0);
        repeat (2) @(posedge clk);
        check_reg({28'h0, bw}, 0);
        check_reg({31'h0, auto_en}, 0);
        final_report();
    end
endmodule
`default_nettype wire
